// ---- design/comparator_control.sv ----
// How it works
// - result high only when positive exceeds negative
// - one select bit picks positive pin
// - two-bit field picks negative source
// - hysteresis off or one of three levels
// - hysteresis codes 0 off, 1..3 rising
// - edge codes both, reserved, falling, rising
// - selected edge sets interrupt flag
// - request needs enable and flag
// - request held until flag or interrupt enable cleared
// - writing one clears flag, zero ignored
// - event follows output whenever enabled
// - low-power bit selects slow low-current mode
// - pin driven only with pin enable
// - invert applies to every consumer
// - idle sleep keeps normal operation
// - standby halts unless run-in-standby set
// - power-down disables comparator and pad
// - debug halt has no effect
// - four byte registers at 0,2,6,7
//
// digital control around one analog comparator
// assumes comparator raw output is asynchronous; register port on clk_sys
//
// The address-and-strobe port was decided locally.
`timescale 1ns/10ps
module comparator_control
   import comparator_pkg::*;
(
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   output logic [7:0] reg_rdata,
   input wire logic [1:0] power_state,
   input wire logic debug_halt,
   input wire logic peripheral_clock_requested,
   input wire logic compare_raw,
   output logic comparator_enable,
   output logic positive_source_select,
   output logic [1:0] negative_source_select,
   output logic [1:0] hysteresis_select,
   output logic low_power_select,
   output logic compare_event,
   output logic pin_output,
   output logic pin_output_enable,
   output logic compare_irq
);
   typedef struct packed
   {
      logic [7:0] control;
      logic [7:0] input_select;
      logic [7:0] irq_enable;
      logic flag;
      logic level_prev;
      logic [7:0] rdata;
      logic active;
      logic pos;
      logic [1:0] neg;
      logic [1:0] hys;
      logic low_power;
      logic event_out;
      logic pad;
      logic pad_en;
      logic irq;
   } ctrl_state_type;

   ctrl_state_type st_r;
   ctrl_state_type st_nxt;
   logic level_sync_q;

   // a write of one clears the flag; a simultaneous edge still sets it
   function automatic logic edge_hit(input logic [1:0] mode, input logic prev, input logic cur);
      logic rise;
      logic fall;
      rise = !prev && cur;
      fall = prev && !cur;
      unique case (edge_type'(mode))
         EDGE_BOTH: edge_hit = rise || fall;
         EDGE_FALL: edge_hit = fall;
         EDGE_RISE: edge_hit = rise;
         EDGE_RESERVED: edge_hit = 1'b0;
      endcase
   endfunction

   function automatic logic wr_hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off,
                                   input logic we);
      wr_hit = we && (a == off);
   endfunction

   // raw result is already high only when positive exceeds negative
   level_sync u_sync
   (
      .clk_sys(clk_sys),
      .resetn(resetn),
      .d(compare_raw),
      .q(level_sync_q)
   );

   always_comb
   begin
      logic running;
      logic clocked;
      logic level;
      logic stat_level;
      logic hit;
      logic [7:0] rd;
      running = 1'b0;
      clocked = 1'b0;
      level = 1'b0;
      stat_level = 1'b0;
      hit = 1'b0;
      rd = 8'h00;
      st_nxt = st_r;

      if (wr_hit(reg_addr, OFF_CONTROL, reg_write))
      begin
         st_nxt.control = reg_wdata;
      end
      if (wr_hit(reg_addr, OFF_INPUT_SELECT, reg_write))
      begin
         st_nxt.input_select = reg_wdata & INPUT_SELECT_MASK;
      end
      if (wr_hit(reg_addr, OFF_IRQ_ENABLE, reg_write))
      begin
         st_nxt.irq_enable = reg_wdata & IRQ_ENABLE_MASK;
      end

      // idle and active and debug halt all run normally
      unique case (power_type'(power_state))
         PWR_ACTIVE, PWR_IDLE:
         begin
            running = st_r.control[BIT_ENABLE];
            clocked = running;
         end
         PWR_STANDBY:
         begin
            running = st_r.control[BIT_ENABLE] && st_r.control[BIT_STANDBY_RUN];
            clocked = running && peripheral_clock_requested;
         end
         PWR_DOWN:
         begin
            running = 1'b0;
            clocked = 1'b0;
         end
      endcase

      // invert ahead of every consumer
      level = level_sync_q ^ st_r.input_select[BIT_INVERT];
      stat_level = running && level;

      st_nxt.active = running;
      st_nxt.pos = st_r.input_select[BIT_POS];
      st_nxt.neg = st_r.input_select[BIT_NEG_LO +: 2];
      st_nxt.hys = st_r.control[BIT_HYS_LO +: 2];
      st_nxt.low_power = st_r.control[BIT_LOW_POWER];
      st_nxt.event_out = stat_level;
      st_nxt.pad_en = running && st_r.control[BIT_PIN_OUT];
      st_nxt.pad = running && st_r.control[BIT_PIN_OUT] && level;

      // status and flag freeze while the peripheral clock is gone
      if (clocked)
      begin
         st_nxt.level_prev = level;
         hit = edge_hit(st_r.control[BIT_EDGE_LO +: 2], st_r.level_prev, level);
      end
      else
      begin
         st_nxt.level_prev = st_r.level_prev;
      end
      if (wr_hit(reg_addr, OFF_STATUS, reg_write) && reg_wdata[BIT_FLAG])
      begin
         st_nxt.flag = 1'b0;
      end
      if (hit)
      begin
         st_nxt.flag = 1'b1;
      end
      st_nxt.irq = st_nxt.flag && st_nxt.irq_enable[0];

      unique case (reg_addr)
         OFF_CONTROL: rd = st_r.control;
         OFF_INPUT_SELECT: rd = st_r.input_select;
         OFF_IRQ_ENABLE: rd = st_r.irq_enable;
         OFF_STATUS:
         begin
            rd = 8'h00;
            rd[BIT_STATE] = st_r.level_prev;
            rd[BIT_FLAG] = st_r.flag;
         end
         default: rd = 8'h00;
      endcase
      st_nxt.rdata = reg_read ? rd : 8'h00;
   end

   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
      begin
         st_r <= '0;
         st_r.control <= CONTROL_RESET;
         st_r.input_select <= INPUT_SELECT_RESET;
         st_r.irq_enable <= IRQ_ENABLE_RESET;
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   assign reg_rdata = st_r.rdata;
   assign comparator_enable = st_r.active;
   assign positive_source_select = st_r.pos;
   assign negative_source_select = st_r.neg;
   assign hysteresis_select = st_r.hys;
   assign low_power_select = st_r.low_power;
   assign compare_event = st_r.event_out;
   assign pin_output = st_r.pad;
   assign pin_output_enable = st_r.pad_en;
   assign compare_irq = st_r.irq;
endmodule

// ---- design/comparator_pkg.sv ----
// comparator control package: register map, field positions, reset values
// assumes an 8-bit register port with byte offsets
package comparator_pkg;
   localparam int unsigned ADDR_W = 3;
   localparam logic [2:0] OFF_CONTROL = 3'h0;
   localparam logic [2:0] OFF_INPUT_SELECT = 3'h2;
   localparam logic [2:0] OFF_IRQ_ENABLE = 3'h6;
   localparam logic [2:0] OFF_STATUS = 3'h7;
   // comparator_control fields
   localparam int unsigned BIT_ENABLE = 0;
   localparam int unsigned BIT_HYS_LO = 1;
   localparam int unsigned BIT_LOW_POWER = 3;
   localparam int unsigned BIT_EDGE_LO = 4;
   localparam int unsigned BIT_PIN_OUT = 6;
   localparam int unsigned BIT_STANDBY_RUN = 7;
   // input_select_control fields
   localparam int unsigned BIT_NEG_LO = 0;
   localparam int unsigned BIT_POS = 3;
   localparam int unsigned BIT_INVERT = 7;
   // status fields
   localparam int unsigned BIT_FLAG = 0;
   localparam int unsigned BIT_STATE = 4;
   localparam logic [7:0] CONTROL_RESET = 8'h00;
   localparam logic [7:0] INPUT_SELECT_RESET = 8'h00;
   localparam logic [7:0] IRQ_ENABLE_RESET = 8'h00;
   localparam logic [7:0] INPUT_SELECT_MASK = 8'h8B;
   localparam logic [7:0] IRQ_ENABLE_MASK = 8'h01;
   localparam int unsigned SYNC_STAGES = 2;
   typedef enum logic [1:0]
   {
      EDGE_BOTH = 2'h0,
      EDGE_RESERVED = 2'h1,
      EDGE_FALL = 2'h2,
      EDGE_RISE = 2'h3
   } edge_type;
   typedef enum logic [1:0]
   {
      HYS_OFF = 2'h0,
      HYS_SMALL = 2'h1,
      HYS_MIDDLE = 2'h2,
      HYS_LARGE = 2'h3
   } hysteresis_type;
   typedef enum logic [1:0]
   {
      NEG_PIN_ZERO = 2'h0,
      NEG_PIN_ONE = 2'h1,
      NEG_REFERENCE = 2'h2,
      NEG_CONVERTER = 2'h3
   } negative_type;
   typedef enum logic [1:0]
   {
      PWR_ACTIVE = 2'h0,
      PWR_IDLE = 2'h1,
      PWR_STANDBY = 2'h2,
      PWR_DOWN = 2'h3
   } power_type;
endpackage

// ---- design/level_sync.sv ----
// two-flop synchroniser for one asynchronous level
// assumes d comes from outside the clk_sys domain
`timescale 1ns/10ps
module level_sync
   import comparator_pkg::*;
(
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic d,
   output logic q
);
   typedef struct packed
   {
      logic [SYNC_STAGES-1:0] stage;
   } sync_state_type;

   sync_state_type st_r;
   sync_state_type st_nxt;

   always_comb
   begin
      st_nxt = st_r;
      st_nxt.stage = {st_r.stage[SYNC_STAGES-2:0], d};
   end

   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
      begin
         st_r <= '0;
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   assign q = st_r.stage[SYNC_STAGES-1];
endmodule

// ---- dv/analog_side.sv ----
// partner: analog pins, reference and converter levels at the comparator
// assumes the bench holds the levels; a disabled comparator reads low
`timescale 1ns/10ps
module analog_side
(
   input wire logic [47:0] levels,
   input wire logic positive_source_select,
   input wire logic [1:0] negative_source_select,
   input wire logic comparator_enable,
   output logic compare_raw
);
   logic [7:0] pos_v;
   logic [7:0] neg_v;
   assign pos_v = levels[8*positive_source_select +: 8];
   assign neg_v = levels[16+8*negative_source_select +: 8];
   assign compare_raw = comparator_enable & (pos_v > neg_v);
endmodule

// ---- dv/comparator_control_props.sv ----
// port checker for comparator_control
// assumes bound to every comparator_control instance
`timescale 1ns/10ps
module comparator_control_props
   import comparator_pkg::*;
(
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   input wire logic [7:0] reg_rdata,
   input wire logic [1:0] power_state,
   input wire logic compare_raw,
   input wire logic comparator_enable,
   input wire logic positive_source_select,
   input wire logic [1:0] negative_source_select,
   input wire logic [1:0] hysteresis_select,
   input wire logic low_power_select,
   input wire logic compare_event,
   input wire logic pin_output,
   input wire logic pin_output_enable,
   input wire logic compare_irq
);
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!resetn);
   sequence s_raw_moves;
      $changed(compare_raw) && comparator_enable;
   endsequence
   property p_sync;
      s_raw_moves |-> ##[1:4] $changed(compare_event);
   endproperty
   a_sync: assert property (p_sync) else $error("event missed raw change");
   property p_irq_hold;
      $fell(compare_irq) |-> $past(reg_write && ((reg_addr == OFF_STATUS && reg_wdata[0])
         || (reg_addr == OFF_IRQ_ENABLE && !reg_wdata[0])));
   endproperty
   a_irq_hold: assert property (p_irq_hold) else $error("request dropped early");
   property p_rdata_idle;
      !$past(reg_read) |-> reg_rdata == 8'h00;
   endproperty
   a_rdata_idle: assert property (p_rdata_idle) else $error("read data without read");
   property p_pdown;
      power_state == PWR_DOWN ##1 power_state == PWR_DOWN |-> !pin_output_enable && !comparator_enable;
   endproperty
   a_pdown: assert property (p_pdown) else $error("active in power down");
   property p_pin_mirror;
      pin_output_enable |-> pin_output == compare_event;
   endproperty
   a_pin_mirror: assert property (p_pin_mirror) else $error("pad differs from event");
   property p_pin_gate;
      reg_write && reg_addr == OFF_CONTROL && !reg_wdata[BIT_PIN_OUT] |-> ##2 !pin_output_enable;
   endproperty
   a_pin_gate: assert property (p_pin_gate) else $error("pad driven while off");
   property p_event_off;
      !comparator_enable [*2] |-> !compare_event;
   endproperty
   a_event_off: assert property (p_event_off) else $error("event while disabled");
   property p_inputs;
      // register copy lands one cycle after the write, the output one cycle later
      reg_write && reg_addr == OFF_INPUT_SELECT && comparator_enable |-> ##2
         positive_source_select == $past(reg_wdata[BIT_POS], 2)
         && negative_source_select == $past(reg_wdata[1:0], 2);
   endproperty
   a_inputs: assert property (p_inputs) else $error("source select wrong");
   property p_control;
      reg_write && reg_addr == OFF_CONTROL && reg_wdata[BIT_ENABLE] && power_state == PWR_ACTIVE
         |-> ##2 hysteresis_select == $past(reg_wdata[2:1], 2)
         && low_power_select == $past(reg_wdata[BIT_LOW_POWER], 2);
   endproperty
   a_control: assert property (p_control) else $error("control fields wrong");
endmodule
bind comparator_control comparator_control_props u_props (.*);

// ---- dv/tb.sv ----
// self-checking bench for comparator_control with analog partner
// assumes comparator_pkg, analog_side and the checker compiled first
`timescale 1ns/10ps
module tb
   import comparator_pkg::*;
;
   logic clk_sys = 1'b0;
   logic resetn = 1'b0;
   logic [2:0] reg_addr = 3'h0;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_write = 1'b0;
   logic reg_read = 1'b0;
   logic [1:0] power_state = 2'h0;
   logic debug_halt = 1'b0;
   logic peripheral_clock_requested = 1'b1;
   logic [47:0] levels = 48'h0;
   logic [7:0] reg_rdata;
   logic compare_raw, comparator_enable, positive_source_select, low_power_select;
   logic [1:0] negative_source_select, hysteresis_select;
   logic compare_event, pin_output, pin_output_enable, compare_irq;
   int errors = 0;
   int n_checks = 0;
   int seed = 32'h233c;
   int i;
   logic [7:0] d;
   logic [7:0] k;
   comparator_control u_dut (.*);
   analog_side u_far (.*);
   always #5 clk_sys = ~clk_sys;
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         errors++;
         $display("mismatch t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [2:0] a, input logic [7:0] v);
      reg_addr <= a;
      reg_wdata <= v;
      reg_write <= 1'b1;
      @(posedge clk_sys);
      reg_write <= 1'b0;
      @(posedge clk_sys);
   endtask
   task automatic rd(input logic [2:0] a, input logic [7:0] exp);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge clk_sys);
      reg_read <= 1'b0;
      #1;
      check(reg_rdata, exp);
      @(posedge clk_sys);
   endtask
   function automatic logic exp_out(input logic [47:0] lv, input logic [7:0] sel);
      return (lv[8*sel[3] +: 8] > lv[16+8*sel[1:0] +: 8]) ^ sel[7];
   endfunction
   function automatic logic exp_flag(input logic [1:0] m, input logic rise);
      return m == EDGE_BOTH || m == (rise ? EDGE_RISE : EDGE_FALL);
   endfunction
   task automatic report_and_stop();
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   initial
   begin
      #900000;
      errors++;
      report_and_stop();
   end
   initial
   begin
      repeat (12) @(posedge clk_sys);
      resetn <= 1'b1;
      @(posedge clk_sys);
      for (i = 0; i < 8; i++)
      begin
         // invert on equal levels reads state high; that rise is flagged in mode 3
         rd(i[2:0], (i == 7) ? 8'h11 : 8'h00);
         if (i < 7)
         begin
            wr(i[2:0], 8'hFF);
            rd(i[2:0], (i == 0) ? 8'hFF : (i == 2) ? INPUT_SELECT_MASK :
               (i == 6) ? IRQ_ENABLE_MASK : 8'h00);
         end
      end
      wr(OFF_INPUT_SELECT, 8'h00);
      $display("done registers");
      for (i = 0; i < 8; i++)
      begin
         debug_halt <= i[0];
         levels <= {40'h0, i[2] ? 8'h00 : 8'h80};
         wr(OFF_CONTROL, {2'b01, i[1:0], 4'h1});
         repeat (6) @(posedge clk_sys);
         wr(OFF_STATUS, 8'h01);
         levels <= {40'h0, i[2] ? 8'h80 : 8'h00};
         repeat (6) @(posedge clk_sys);
         d = {3'h0, i[2], 3'h0, exp_flag(i[1:0], i[2])};
         rd(OFF_STATUS, d);
         check({7'h0, compare_irq}, {7'h0, d[0]});
         wr(OFF_STATUS, 8'hFE);
         rd(OFF_STATUS, d);
         wr(OFF_STATUS, 8'h01);
         check({7'h0, compare_irq}, 8'h00);
      end
      $display("done edges");
      for (i = 0; i < 40; i++)
      begin
         d = 8'($random(seed)) & INPUT_SELECT_MASK;
         d[1:0] = i[1:0];
         k = 8'($random(seed));
         levels <= 48'({$random(seed), $random(seed)});
         wr(OFF_CONTROL, {4'h4, k[2:0], 1'b1});
         wr(OFF_INPUT_SELECT, d);
         repeat (5) @(posedge clk_sys);
         check({5'h0, low_power_select, hysteresis_select}, {5'h0, k[2:0]});
         check({6'h0, pin_output, compare_event}, {6'h0, {2{exp_out(levels, d)}}});
         wr(OFF_STATUS, 8'h01);
         rd(OFF_STATUS, {3'h0, exp_out(levels, d), 4'h0});
      end
      $display("done sources");
      wr(OFF_CONTROL, 8'hC1);
      peripheral_clock_requested <= 1'b0;
      power_state <= PWR_STANDBY;
      levels <= ~levels;
      repeat (5) @(posedge clk_sys);
      check({7'h0, compare_event}, {7'h0, exp_out(levels, d)});
      rd(OFF_STATUS, {3'h0, exp_out(~levels, d), 4'h0});
      wr(OFF_CONTROL, 8'h41);
      repeat (3) @(posedge clk_sys);
      check({7'h0, comparator_enable}, 8'h00);
      power_state <= PWR_IDLE;
      repeat (3) @(posedge clk_sys);
      check({7'h0, comparator_enable}, 8'h01);
      power_state <= PWR_DOWN;
      repeat (3) @(posedge clk_sys);
      check({6'h0, comparator_enable, pin_output_enable}, 8'h00);
      power_state <= PWR_ACTIVE;
      wr(OFF_CONTROL, 8'h01);
      repeat (2) @(posedge clk_sys);
      check({6'h0, comparator_enable, pin_output_enable}, 8'h02);
      $display("done power");
      report_and_stop();
   end
endmodule
